// ===== hw/tmr_regs.svh
// register map, field positions, status codes and bit timing of the master receiver
// assumes a 20 MHz core clock; included by the package and the design
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_OFS_CTRL   2'h0
`define TMR_OFS_STATUS 2'h1
`define TMR_OFS_DATA   2'h2
`define TMR_CTL_FLAG   7
`define TMR_CTL_ACK    6
`define TMR_CTL_STA    5
`define TMR_CTL_STO    4
`define TMR_CTL_WCOL   3
`define TMR_CTL_EN     2
`define TMR_CTL_IE     0
`define TMR_RST_CTRL   8'h00
`define TMR_RST_STATUS 8'hf8
`define TMR_RST_DATA   8'hff
`define TMR_ST_START   8'h08
`define TMR_ST_RSTART  8'h10
`define TMR_ST_WA_ACK  8'h18
`define TMR_ST_WA_NACK 8'h20
`define TMR_ST_LOST    8'h38
`define TMR_ST_RA_ACK  8'h40
`define TMR_ST_RA_NACK 8'h48
`define TMR_ST_RX_ACK  8'h50
`define TMR_ST_RX_NACK 8'h58
`define TMR_CLK_NS     50
`define TMR_QUARTER_NS 2500
`define TMR_QUARTER_CYC (`TMR_QUARTER_NS / `TMR_CLK_NS)
`endif

// ===== hw/tmr_pkg.sv
// types of the master receiver: register request, engine states, whole state
// assumes tmr_regs.svh sits beside it
package tmr_pkg;
  `include "tmr_regs.svh"

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr_reg_req_t;

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_FREE, S_START, S_XFER, S_HOLD, S_STOP, S_LOST
  } tmr_state_t;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_prev;
    logic       busy;
    tmr_state_t st;
    logic [1:0] phase;
    logic [15:0] qcnt;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic       tx;
    logic       rw;
    logic       ack_rx;
    logic       rep;
    logic       restart;
    logic       op_done_flag;
    logic       ack_enable;
    logic       start_request;
    logic       stop_request;
    logic       write_collision_flag;
    logic       iface_enable;
    logic       irq_enable;
    logic [7:0] status;
    logic [7:0] data;
    logic       scl_low;
    logic       sda_low;
    logic [7:0] rdata;
  } tmr_state_all_t;
endpackage

// ===== hw/tmr_master_rx.sv
// two-wire master receiver: start, read address, byte reception with ack/nack, stop
// assumes open-drain scl/sda resolved outside; pin inputs are asynchronous
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "tmr_regs.svh"

module tmr_master_rx
  import tmr_pkg::*;
#(
  parameter int QUARTER_CYCLES = `TMR_QUARTER_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire tmr_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire logic         scl_in,
  output logic              scl_out,
  output logic              scl_oe,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe
);

  if (QUARTER_CYCLES < 2 || QUARTER_CYCLES > 65535) begin : g_bad_quarter
    $error("QUARTER_CYCLES out of range");
  end

  localparam logic [15:0] QRELOAD = 16'(QUARTER_CYCLES - 1);

  tmr_state_all_t s;
  tmr_state_all_t n;
  logic           tick;
  logic           bit_val;

  function automatic logic [7:0] ctl_byte(input tmr_state_all_t v);
    logic [7:0] b;
    b = 8'h00;
    b[`TMR_CTL_FLAG] = v.op_done_flag;
    b[`TMR_CTL_ACK]  = v.ack_enable;
    b[`TMR_CTL_STA]  = v.start_request;
    b[`TMR_CTL_STO]  = v.stop_request;
    b[`TMR_CTL_WCOL] = v.write_collision_flag;
    b[`TMR_CTL_EN]   = v.iface_enable;
    b[`TMR_CTL_IE]   = v.irq_enable;
    return b;
  endfunction

  function automatic logic is_code(input logic [7:0] st, input logic [7:0] a, input logic [7:0] b);
    return (st == a) || (st == b);
  endfunction

  always_comb begin
    n = s;
    tick = 1'b0;
    n.scl_s1 = scl_in;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = sda_in;
    n.sda_s2 = s.sda_s1;
    n.sda_prev = s.sda_s2;
    n.rdata = 8'h00;
    bit_val = 1'b1;

    // any master's start marks the bus busy, a stop frees it
    if (s.scl_s2 && s.sda_prev && !s.sda_s2) begin
      n.busy = 1'b1;
    end
    if (s.scl_s2 && !s.sda_prev && s.sda_s2) begin
      n.busy = 1'b0;
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        `TMR_OFS_CTRL:   n.rdata = ctl_byte(s);
        `TMR_OFS_STATUS: n.rdata = {s.status[7:2], 2'b00};
        `TMR_OFS_DATA:   n.rdata = s.data;
        default:         n.rdata = 8'h00;
      endcase
    end

    if (reg_req.wr) begin
      case (reg_req.addr)
        `TMR_OFS_CTRL: begin
          if (reg_req.wdata[`TMR_CTL_FLAG]) begin
            n.op_done_flag = 1'b0;
          end
          n.ack_enable    = reg_req.wdata[`TMR_CTL_ACK];
          n.start_request = reg_req.wdata[`TMR_CTL_STA];
          n.stop_request  = reg_req.wdata[`TMR_CTL_STO];
          n.iface_enable  = reg_req.wdata[`TMR_CTL_EN];
          n.irq_enable    = reg_req.wdata[`TMR_CTL_IE];
        end
        `TMR_OFS_DATA: begin
          // the data register is only safe to load while the engine is parked
          if (s.op_done_flag) begin
            n.data = reg_req.wdata;
            n.write_collision_flag = 1'b0;
          end else begin
            n.write_collision_flag = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // quarter-bit timebase; stalls in the high phase while a slave stretches scl
    if (s.qcnt != 16'h0000) begin
      n.qcnt = s.qcnt - 16'h0001;
    end else if (!(s.phase == 2'd2 && !s.scl_s2)) begin
      n.qcnt = QRELOAD;
      tick = 1'b1;
      n.phase = s.phase + 2'd1;
    end

    case (s.st)
      S_IDLE: begin
        n.scl_low = 1'b0;
        n.sda_low = 1'b0;
        if (s.iface_enable && s.start_request && !s.op_done_flag) begin
          n.st = S_WAIT_FREE;
          n.rep = 1'b0;
        end
      end
      S_WAIT_FREE: begin
        if (!s.busy) begin
          n.st = S_START;
        end
      end
      S_START: begin
        // works from an idle bus and, with scl low, as a repeated start
        if (tick) begin
          case (s.phase)
            2'd0: n.sda_low = 1'b0;
            2'd1: n.scl_low = 1'b0;
            2'd2: n.sda_low = 1'b1;
            default: begin
              n.scl_low = 1'b1;
              n.op_done_flag = 1'b1;
              n.status = s.rep ? `TMR_ST_RSTART : `TMR_ST_START;
              n.st = S_HOLD;
            end
          endcase
        end
      end
      S_XFER: begin
        if (s.bitn == 4'd8) begin
          bit_val = s.tx || !s.ack_enable;
        end else begin
          bit_val = !s.tx || s.shift[7];
        end
        if (tick) begin
          case (s.phase)
            2'd0: n.sda_low = !bit_val;
            2'd1: n.scl_low = 1'b0;
            2'd2: begin
              if (s.bitn == 4'd8) begin
                n.ack_rx = s.sda_s2;
              end else if (s.tx && bit_val && !s.sda_s2) begin
                n.sda_low = 1'b0;
                // pulling scl now cuts the winner's high phase short and, held until the flag clears, stretches its low phase; its receivers sampled on the rise
                n.scl_low = 1'b1;
                n.status = `TMR_ST_LOST;
                n.op_done_flag = 1'b1;
                n.st = S_LOST;
              end else begin
                n.shift = {s.shift[6:0], s.sda_s2};
              end
            end
            default: begin
              n.scl_low = 1'b1;
              if (s.bitn != 4'd8) begin
                n.bitn = s.bitn + 4'd1;
              end else begin
                n.op_done_flag = 1'b1;
                if (!s.tx) begin
                  n.data = s.shift;
                  n.status = s.ack_enable ? `TMR_ST_RX_ACK : `TMR_ST_RX_NACK;
                end else if (s.rw) begin
                  n.status = s.ack_rx ? `TMR_ST_RA_NACK : `TMR_ST_RA_ACK;
                end else begin
                  n.status = s.ack_rx ? `TMR_ST_WA_NACK : `TMR_ST_WA_ACK;
                end
                n.st = S_HOLD;
              end
            end
          endcase
        end
      end
      S_HOLD: begin
        n.scl_low = 1'b1;
        if (!s.op_done_flag) begin
          if (s.stop_request) begin
            n.st = S_STOP;
            n.restart = s.start_request;
          end else if (s.start_request) begin
            n.st = S_START;
            n.rep = 1'b1;
          end else if (is_code(s.status, `TMR_ST_START, `TMR_ST_RSTART)) begin
            n.st = S_XFER;
            n.tx = 1'b1;
            n.rw = s.data[0];
            n.shift = s.data;
            n.bitn = 4'd0;
          end else if (is_code(s.status, `TMR_ST_RA_ACK, `TMR_ST_RX_ACK)) begin
            n.st = S_XFER;
            n.tx = 1'b0;
            n.bitn = 4'd0;
          end
        end
      end
      S_STOP: begin
        if (tick) begin
          case (s.phase)
            2'd0: n.sda_low = 1'b1;
            2'd1: n.scl_low = 1'b0;
            2'd2: n.sda_low = 1'b0;
            default: begin
              n.stop_request = 1'b0;
              n.rep = 1'b0;
              n.st = s.restart ? S_WAIT_FREE : S_IDLE;
            end
          endcase
        end
      end
      S_LOST: begin
        // sda is let go at once; scl stays low like any parked state until the flag clears
        n.sda_low = 1'b0;
        n.scl_low = s.op_done_flag;
        if (!s.op_done_flag) begin
          n.rep = 1'b0;
          n.st = s.start_request ? S_WAIT_FREE : S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase

    if (!s.iface_enable) begin
      n.st = S_IDLE;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
    end
    if (n.st != s.st) begin
      n.phase = 2'd0;
      n.qcnt = QRELOAD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= S_IDLE;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_prev <= 1'b1;
      s.status <= `TMR_RST_STATUS;
      s.data <= `TMR_RST_DATA;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign scl_out   = 1'b0;
  assign scl_oe    = s.scl_low;
  assign sda_out   = 1'b0;
  assign sda_oe    = s.sda_low;

endmodule

// ===== test/tmr_slave_model.sv
// slave transmitter on the open-drain bus: acks its address, sends tx_byte per byte
// assumes pull-ups on scl and sda, with the wires resolved in the bench
`timescale 1ns/1ps
module tmr_slave_model #(
  parameter logic [6:0] ADR = 7'h2a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  input  wire logic       stretch,
  output logic            sda_low,
  output logic            scl_low
);
  int         n;
  logic [7:0] sh;
  logic [7:0] tx;
  logic       on;
  logic       adr;
  logic       send;
  initial begin
    {sda_low, scl_low, on, adr, send} = '0;
    n = 0;
  end
  always @(negedge sda) if (scl) begin
    on = 1;
    adr = 1;
    n = 0;
  end
  always @(posedge sda) if (scl) on = 0;
  always @(posedge scl) if (on) begin
    n = n + 1;
    sh = {sh[6:0], sda};
    // a nack from the master ends the read
    if (n == 9 && !adr) send = send && !sda;
  end
  // lines change only while scl is low; a released line floats up
  always @(negedge scl) if (on) begin
    if (n == 8 && adr) begin
      sda_low = sh[7:1] == ADR;
      send = sh[7:1] == ADR && sh[0];
    end else if (n == 9) begin
      n = 0;
      adr = 0;
      tx = tx_byte;
      sda_low = send && !tx[7];
    end else sda_low = send && !adr && n < 8 && !tx[7 - n];
    if (stretch) begin
      scl_low = 1;
      #300 scl_low = 0;
    end
  end
endmodule

// ===== test/tmr_assertions.sv
// checker of the master receiver ports: read timing, flag hold, bus conditions
// assumes a bind to tmr_master_rx with QUARTER_CYCLES of at least 2
`timescale 1ns/1ps
module tmr_assertions
  import tmr_pkg::*;
#(
  parameter int QUARTER_CYCLES = 2
) (
  input wire logic         core_clk,
  input wire logic         rst,
  input wire tmr_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire logic         scl_in,
  input wire logic         scl_out,
  input wire logic         scl_oe,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe
);
  localparam int QW = QUARTER_CYCLES + 1;
  logic ctl_rd;
  logic st_rd;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  assign ctl_rd = reg_req.rd && reg_req.addr == 2'h0;
  assign st_rd  = reg_req.rd && reg_req.addr == 2'h1;
  property p_rdata_idle; !reg_req.rd |=> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
  property p_unmapped; reg_req.rd && reg_req.addr == 2'h3 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_low; st_rd |=> reg_rdata[1:0] == 2'h0; endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits set");
  property p_flag_scl; ctl_rd ##1 reg_rdata[7] |-> scl_oe; endproperty
  a_flag_scl: assert property (p_flag_scl) else $error("scl released while flag set");
  property p_flag_clear; reg_req.wr && reg_req.addr == 2'h0 && reg_req.wdata[7] ##[1:2] ctl_rd |=> !reg_rdata[7];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write");
  // start: sda pulled while scl is free, then scl follows within a quarter plus one cycle
  property p_start; $rose(sda_oe) && !scl_oe |-> ##[1:QW] scl_oe; endproperty
  a_start: assert property (p_start) else $error("start not followed by scl low");
  property p_stop; $fell(sda_oe) && !scl_oe |-> (!sda_oe && !scl_oe) [*3]; endproperty
  a_stop: assert property (p_stop) else $error("bus not left free after stop");
  property p_disable; reg_req.wr && reg_req.addr == 2'h0 && !reg_req.wdata[2] |-> ##[1:3] !scl_oe && !sda_oe;
  endproperty
  a_disable: assert property (p_disable) else $error("bus held with interface disabled");
  c_addr_ack: cover property (st_rd ##1 reg_rdata == 8'h40);
  c_rx_ack: cover property (st_rd ##1 reg_rdata == 8'h50);
  c_rx_nack: cover property (st_rd ##1 reg_rdata == 8'h58);
  c_lost: cover property (st_rd ##1 reg_rdata == 8'h38);
endmodule
bind tmr_master_rx tmr_assertions #(.QUARTER_CYCLES(QUARTER_CYCLES)) tmr_assertions_inst (
  .core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// ===== test/tmr_master_rx_bench.sv
// bench: register-driven master receive flows checked against a queue of sent bytes
// assumes the slave model answers address 2a; quarter bit of 2 cycles gives a 450 ns scl, the high quarter one cycle longer for the synchronizer
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tmr_master_rx_bench;
  import tmr_pkg::*;
  logic         core_clk, rst, scl_out, scl_oe, sda_out, sda_oe, s_low, k_low, stretch, rival;
  tmr_reg_req_t reg_req;
  logic [7:0]   reg_rdata, tx_byte, v, e;
  logic [7:0]   rv [4] = '{8'h00, 8'hf8, 8'hff, 8'h00};
  logic [7:0]   exp_q [$];
  int           fails, n_compared, seed, j, k;
  wire          scl = ~scl_oe & ~k_low;
  // rival stands in for a second master that holds sda low during an address
  wire          sda = ~sda_oe & ~s_low & ~rival;
  tmr_master_rx #(.QUARTER_CYCLES(2)) tmr_master_rx_inst (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe));
  tmr_slave_model tmr_slave_model_inst (.scl(scl), .sda(sda), .tx_byte(tx_byte), .stretch(stretch),
    .sda_low(s_low), .scl_low(k_low));
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask
  // bounded poll of one control bit; running out ends the run
  task automatic wait_ctl(input int b, input logic val);
    for (k = 0; k < 400; k++) begin
      rd(2'h0, v);
      if (v[b] === val) return;
    end
    fails++;
    conclude();
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    wr(2'h0, c);
    wait_ctl(7, 1'b1);
    rd(2'h1, v);
    `CHK("status", st, v & 8'hf8)
  endtask
  task automatic next_byte;
    e = 8'($random(seed));
    tx_byte <= e;
    exp_q.push_back(e);
  endtask
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {fails, n_compared} = '0;
    seed = 32'h2fd2;
    rst = 1;
    reg_req = '0;
    tx_byte = 8'h00;
    stretch = 0;
    rival = 0;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    for (j = 0; j < 4; j++) begin
      rd(j[1:0], v);
      `CHK("reset", rv[j], v)
    end
    `CHK("pins", 2'b00, {scl_out, sda_out})
    $display("test reset done");
    next_byte();
    step(8'ha4, 8'h08);
    wr(2'h2, 8'h55);
    step(8'h84, 8'h40);
    for (j = 0; j < 3; j++) begin
      next_byte();
      stretch <= j[0];
      step(j < 2 ? 8'hc4 : 8'h84, j < 2 ? 8'h50 : 8'h58);
      rd(2'h2, v);
      e = exp_q.pop_front();
      `CHK("byte", e, v)
    end
    $display("test receive done");
    step(8'ha4, 8'h10);
    wr(2'h2, 8'h33);
    step(8'h84, 8'h48);
    step(8'hb4, 8'h08);
    wr(2'h2, 8'h55);
    step(8'h84, 8'h40);
    step(8'h84, 8'h58);
    rd(2'h2, v);
    e = exp_q.pop_front();
    `CHK("byte", e, v)
    step(8'ha4, 8'h10);
    wr(2'h2, 8'h54);
    step(8'h84, 8'h18);
    $display("test restart done");
    wr(2'h0, 8'h94);
    wait_ctl(4, 1'b0);
    `CHK("ctrl", 8'h04, v)
    `CHK("bus", 1'b1, scl & sda)
    wr(2'h2, 8'h5a);
    rd(2'h0, v);
    `CHK("ctrl", 8'h0c, v)
    rd(2'h2, v);
    `CHK("data", 8'h54, v)
    $display("test stop done");
    step(8'ha4, 8'h08);
    wr(2'h2, 8'hff);
    rival <= 1'b1;
    step(8'h84, 8'h38);
    rival <= 1'b0;
    wr(2'h0, 8'h84);
    rd(2'h0, v);
    `CHK("ctrl", 8'h04, v)
    `CHK("bus", 1'b1, scl & sda)
    wr(2'h0, 8'h00);
    repeat (4) @(posedge core_clk);
    $display("test lost done");
    conclude();
  end
endmodule
